//--- common/nvm_cmd_pkg.sv
// Purpose: Shared constants and types for the nonvolatile memory command interface
// Assumes: 32-bit peripheral register bus with byte strobes, one system clock
// Notes:   Offsets are byte addresses; all registers occupy one aligned word

package nvm_cmd_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_COMMAND_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_CONTROLLER_CONFIG  = 8'h04;
   localparam logic [7:0] OFS_MEMORY_PARAMETERS  = 8'h08;
   localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR   = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ENABLE_SET     = 8'h10;
   localparam logic [7:0] OFS_IRQ_FLAGS          = 8'h14;
   localparam logic [7:0] OFS_CONTROLLER_STATE   = 8'h18;
   localparam logic [7:0] OFS_TARGET_LOCATION    = 8'h1C;
   localparam logic [7:0] OFS_REGION_LOCK_BITS   = 8'h20;

   // ==========================================================
   // Command control fields
   localparam int         CMD_LSB                = 0;
   localparam int         CMD_W                  = 7;
   localparam int         KEY_LSB                = 8;
   localparam int         KEY_W                  = 8;
   localparam logic [7:0] EXECUTION_KEY_VALUE    = 8'hA5;
   localparam logic [15:0] COMMAND_CONTROL_RESET = 16'h0000;

   // Command codes
   localparam logic [6:0] CODE_MAIN_ROW_ERASE    = 7'h02;
   localparam logic [6:0] CODE_PAGE_WRITE        = 7'h04;
   localparam logic [6:0] CODE_AUX_ROW_ERASE     = 7'h05;

   // ==========================================================
   // Controller config fields
   localparam logic [31:0] CONFIG_RESET          = 32'h0000_0080;
   localparam logic [31:0] CONFIG_WRITE_MASK     = 32'h0007_039E;
   localparam int          CFG_MANW_BIT          = 7;
   localparam int          CFG_WAIT_LSB          = 1;
   localparam int          CFG_SLEEP_LSB         = 8;
   localparam int          CFG_READMODE_LSB      = 16;
   localparam int          CFG_CACHEDIS_BIT      = 18;

   // ==========================================================
   // Irq and state bit positions
   localparam int         IRQ_READY_BIT          = 0;
   localparam int         IRQ_ERROR_BIT          = 1;
   localparam logic [1:0] IRQ_ENABLE_RESET       = 2'h0;
   localparam int         ST_PRM_BIT             = 0;
   localparam int         ST_LOAD_BIT            = 1;
   localparam int         ST_PROG_ERR_BIT        = 2;
   localparam int         ST_LOCK_ERR_BIT        = 3;
   localparam int         ST_NVME_BIT            = 4;
   localparam int         ST_SB_BIT              = 8;

   // ==========================================================
   // Location and parameter layout
   localparam int         LOCATION_W             = 22;
   localparam logic [21:0] LOCATION_RESET        = 22'h00_0000;
   localparam int         MEMORY_PARAMETERS_PSZ_LSB          = 16;
   localparam int         MEMORY_PARAMETERS_RWWEEP_LSB       = 20;
   localparam logic [15:0] LOCK_RESET            = 16'hFFFF;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      OP_NONE       = 2'b00,
      OP_MAIN_ERASE = 2'b01,
      OP_PAGE_WRITE = 2'b10,
      OP_AUX_ERASE  = 2'b11
   } array_op_t;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_PEND  = 2'b01,
      SEQ_START = 2'b10,
      SEQ_WAIT  = 2'b11
   } seq_state_t;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [3:0]  strb;
   } reg_req_t;

   typedef struct packed {
      logic        start;
      array_op_t   op;
      logic [21:0] location;
   } array_cmd_t;

   typedef struct packed {
      array_op_t   op;
      logic        lock_fail;
      logic        prog_fail;
   } decode_t;

endpackage : nvm_cmd_pkg

//--- hw/nvm_cmd_decode.sv
// Purpose: Classifies a command code into an array operation or an error
// Assumes: Location is in 16-bit halfword units
// Notes:   Purely combinational; the caller registers the result

`timescale 1ns/1ps

module nvm_cmd_decode
   import nvm_cmd_pkg::*;
#(
   parameter int REGION_SHIFT  = 12,
   parameter int ROW_SHIFT     = 7,
   parameter logic [21:0] USER_ROW_LOCATION = 22'h00_0000
) (
   // Command and context
   input  wire logic [6:0]  code,
   input  wire logic [21:0] location,
   input  wire logic        security_set,
   input  wire logic [15:0] lock_bits,
   // Result
   output decode_t          result
);

   logic [3:0] region;

   // ==========================================================
   // Decode
   always_comb begin
      region = 4'(location >> REGION_SHIFT);
      result = '{op: OP_NONE, lock_fail: 1'b0, prog_fail: 1'b0};
      unique case (code)
         CODE_MAIN_ROW_ERASE: begin
            // A cleared lock bit marks the region locked
            if (!lock_bits[region]) begin
               result.lock_fail = 1'b1;
            end else begin
               result.op = OP_MAIN_ERASE;
            end
         end
         CODE_PAGE_WRITE: begin
            result.op = OP_PAGE_WRITE;
         end
         CODE_AUX_ROW_ERASE: begin
            if (security_set || ((location >> ROW_SHIFT) != (USER_ROW_LOCATION >> ROW_SHIFT))) begin
               result.prog_fail = 1'b1;
            end else begin
               result.op = OP_AUX_ERASE;
            end
         end
         default: begin
            result.op = OP_NONE;
         end
      endcase
   end

endmodule : nvm_cmd_decode

//--- hw/nvm_command_register_interface.sv
// Purpose: Register map and command issue logic of a nonvolatile memory controller
// Assumes: Memory-bus and array signals are on clk; the array pulses done when an op ends
// Notes:   Register bus answers with no wait states; unmapped offsets give an error
//
// Behaviour
// - A command runs only when the key 0xA5 arrives in the same write.
// - Any other key value blocks the command and sets the programming error flag.
// - Issuing while a command is unfinished sets the programming error flag.
// - A memory-bus access in the command cycle is served first.
// - A deferred command starts once array and memory bus are idle.
// - Lowest key bit reads one until the command has been issued.
// - The target location counts 16-bit halfwords, not bytes.
// - Code 0x02 erases the main-array row holding the target location.
// - Code 0x04 programs the page buffer into the targeted page.
// - Code 0x05 erases the user configuration row, only with security clear.
// - Accesses of 8, 16 and 32 bits and their byte parts are accepted.
// - Enable-protected registers ignore writes while the module is enabled.
// - Ready flag stays low and memory bus stalls while programming runs.
// - Main row erase into a locked region is skipped and sets the lock error flag.

`timescale 1ns/1ps

module nvm_command_register_interface
   import nvm_cmd_pkg::*;
#(
   parameter int          REGION_SHIFT      = 12,
   parameter int          ROW_SHIFT         = 7,
   parameter logic [21:0] USER_ROW_LOCATION = 22'h00_0000,
   parameter logic [15:0] PAGE_COUNT        = 16'h0400,
   parameter logic [2:0]  PAGE_SIZE_CODE    = 3'h3,
   parameter logic [11:0] AUX_PAGE_COUNT    = 12'h020
) (
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Peripheral register bus
   input  reg_req_t         req,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Memory bus activity
   input  wire logic        mem_access,
   input  wire logic        mem_busy,
   input  wire logic        mem_addr_load,
   input  wire logic [21:0] mem_addr,
   output logic             mem_stall,
   // Memory array
   output array_cmd_t       array_cmd,
   input  wire logic        array_idle,
   input  wire logic        array_done,
   input  wire logic        array_fault,
   // Device context
   input  wire logic        module_enabled,
   input  wire logic        security_set,
   input  wire logic        page_loaded,
   output logic [31:0]      config_out
);

   // ==========================================================
   // State
   seq_state_t  state,       next_state;
   logic [6:0]  cmd,         next_cmd;
   logic [7:0]  key,         next_key;
   logic [31:0] cfg,         next_cfg;
   logic [1:0]  irq_en,      next_irq_en;
   logic        irq_err,     next_irq_err;
   logic        prog_err,    next_prog_err;
   logic        lock_err,    next_lock_err;
   logic        array_err,   next_array_err;
   logic [21:0] location,    next_location;
   logic [15:0] lock_bits;
   array_op_t   op_held,     next_op_held;
   logic [21:0] op_loc,      next_op_loc;
   logic [31:0] rdata,       next_rdata;
   logic        rerr,        next_rerr;

   logic        access;
   logic        wr;
   logic        mapped;
   logic [31:0] wmask;
   logic        cmd_write;
   logic        key_ok;
   logic [6:0]  cmd_new;
   logic        set_prog;
   logic        set_lock;
   logic [15:0] state_word;
   logic [31:0] read_word;
   decode_t     dec;

   // ==========================================================
   // Bus decode
   assign access = req.sel && req.enable;
   assign wr     = access && req.write;
   assign pready = 1'b1;

   // Byte strobes widen to a bit mask so any lane mix works
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{req.strb[i]}};
      end
   end

   always_comb begin
      unique case (req.addr)
         OFS_COMMAND_CONTROL, OFS_CONTROLLER_CONFIG, OFS_MEMORY_PARAMETERS,
         OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_ENABLE_SET, OFS_IRQ_FLAGS,
         OFS_CONTROLLER_STATE, OFS_TARGET_LOCATION, OFS_REGION_LOCK_BITS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ==========================================================
   // Command acceptance
   // Only a write touching the key byte can issue; without the command byte the stored code is used
   assign cmd_write = wr && (req.addr == OFS_COMMAND_CONTROL) && req.strb[1];
   assign key_ok    = req.wdata[KEY_LSB +: KEY_W] == EXECUTION_KEY_VALUE;
   assign cmd_new   = req.strb[0] ? req.wdata[CMD_LSB +: CMD_W] : cmd;

   nvm_cmd_decode #(
      .REGION_SHIFT      (REGION_SHIFT),
      .ROW_SHIFT         (ROW_SHIFT),
      .USER_ROW_LOCATION (USER_ROW_LOCATION)
   ) u_decode (
      .code         (cmd_new),
      .location     (location),
      .security_set (security_set),
      .lock_bits    (lock_bits),
      .result       (dec)
   );

   always_comb begin
      set_prog = 1'b0;
      set_lock = 1'b0;
      if (cmd_write) begin
         if (!key_ok) begin
            set_prog = 1'b1;
         end else if (state != SEQ_IDLE) begin
            set_prog = 1'b1;
         end else begin
            set_prog = dec.prog_fail;
            set_lock = dec.lock_fail;
         end
      end
   end

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state   = state;
      next_op_held = op_held;
      next_op_loc  = op_loc;
      unique case (state)
         SEQ_IDLE: begin
            if (cmd_write && key_ok && !dec.prog_fail && !dec.lock_fail && dec.op != OP_NONE) begin
               next_op_held = dec.op;
               next_op_loc  = location;
               next_state   = SEQ_PEND;
            end
         end
         SEQ_PEND: begin
            // Memory-bus traffic keeps priority; wait for it and the array to go quiet
            if (!mem_access && !mem_busy && array_idle) begin
               next_state = SEQ_START;
            end
         end
         SEQ_START: begin
            next_state = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (array_done) begin
               next_state   = SEQ_IDLE;
               next_op_held = OP_NONE;
            end
         end
      endcase
   end

   assign array_cmd = '{start: state == SEQ_START, op: op_held, location: op_loc};
   assign mem_stall = (state == SEQ_START) || (state == SEQ_WAIT);

   // ==========================================================
   // Register writes
   always_comb begin
      next_cmd       = cmd;
      next_key       = key;
      next_cfg       = cfg;
      next_irq_en    = irq_en;
      next_location  = location;
      next_prog_err  = prog_err;
      next_lock_err  = lock_err;
      next_array_err = array_err;
      next_irq_err   = irq_err;
      if (wr) begin
         unique case (req.addr)
            OFS_COMMAND_CONTROL: begin
               if (req.strb[0]) begin
                  next_cmd = req.wdata[CMD_LSB +: CMD_W];
               end
               if (req.strb[1]) begin
                  next_key = req.wdata[KEY_LSB +: KEY_W];
               end
            end
            OFS_CONTROLLER_CONFIG: begin
               if (!module_enabled) begin
                  next_cfg = (cfg & ~(wmask & CONFIG_WRITE_MASK)) | (req.wdata & wmask & CONFIG_WRITE_MASK);
               end
            end
            OFS_IRQ_ENABLE_CLEAR: begin
               if (req.strb[0]) begin
                  next_irq_en = irq_en & ~req.wdata[1:0];
               end
            end
            OFS_IRQ_ENABLE_SET: begin
               if (req.strb[0]) begin
                  next_irq_en = irq_en | req.wdata[1:0];
               end
            end
            OFS_IRQ_FLAGS: begin
               if (req.strb[0] && req.wdata[IRQ_ERROR_BIT]) begin
                  next_irq_err = 1'b0;
               end
            end
            OFS_CONTROLLER_STATE: begin
               if (req.strb[0]) begin
                  next_prog_err  = prog_err  & ~req.wdata[ST_PROG_ERR_BIT];
                  next_lock_err  = lock_err  & ~req.wdata[ST_LOCK_ERR_BIT];
                  next_array_err = array_err & ~req.wdata[ST_NVME_BIT];
               end
            end
            OFS_TARGET_LOCATION: begin
               next_location = (location & ~wmask[21:0]) | (req.wdata[21:0] & wmask[21:0]);
            end
            default: begin
            end
         endcase
      end
      // Memory-bus page loads record their halfword location
      if (mem_addr_load) begin
         next_location = mem_addr;
      end
      // Hardware sets win over a clear in the same cycle
      if (set_prog) begin
         next_prog_err = 1'b1;
      end
      if (set_lock) begin
         next_lock_err = 1'b1;
      end
      if (array_fault && state == SEQ_WAIT) begin
         next_array_err = 1'b1;
      end
      if (set_prog || set_lock) begin
         next_irq_err = 1'b1;
      end
   end

   // ==========================================================
   // Read path
   always_comb begin
      state_word               = 16'h0000;
      state_word[ST_LOAD_BIT]  = page_loaded;
      state_word[ST_PROG_ERR_BIT] = prog_err;
      state_word[ST_LOCK_ERR_BIT] = lock_err;
      state_word[ST_NVME_BIT]  = array_err;
      state_word[ST_SB_BIT]    = security_set;
      read_word                = 32'h0000_0000;
      unique case (req.addr)
         OFS_COMMAND_CONTROL: begin
            read_word[CMD_LSB +: CMD_W] = cmd;
            read_word[KEY_LSB +: KEY_W] = key;
            // Shows one while a keyed command waits to be issued
            if (state == SEQ_PEND) begin
               read_word[KEY_LSB] = 1'b1;
            end
         end
         OFS_CONTROLLER_CONFIG: read_word = cfg;
         OFS_MEMORY_PARAMETERS: begin
            read_word[15:0]                   = PAGE_COUNT;
            read_word[MEMORY_PARAMETERS_PSZ_LSB +: 3]     = PAGE_SIZE_CODE;
            read_word[MEMORY_PARAMETERS_RWWEEP_LSB +: 12] = AUX_PAGE_COUNT;
         end
         OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_ENABLE_SET: read_word[1:0] = irq_en;
         OFS_IRQ_FLAGS: begin
            read_word[IRQ_READY_BIT] = (state == SEQ_IDLE);
            read_word[IRQ_ERROR_BIT] = irq_err;
         end
         OFS_CONTROLLER_STATE: read_word[15:0] = state_word;
         OFS_TARGET_LOCATION:  read_word[21:0] = location;
         OFS_REGION_LOCK_BITS: read_word[15:0] = lock_bits;
         default: read_word = 32'h0000_0000;
      endcase
      next_rdata = rdata;
      next_rerr  = 1'b0;
      if (access) begin
         next_rdata = req.write ? rdata : read_word;
         next_rerr  = !mapped;
      end
   end

   // Read data and error come from flops, so they stand one cycle after the access
   assign prdata     = rdata;
   assign pslverr    = rerr;
   assign config_out = cfg;
   // Lock commands are not handled here, so the lock bits stay at reset
   assign lock_bits  = LOCK_RESET;

   // ==========================================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= SEQ_IDLE;
         cmd       <= COMMAND_CONTROL_RESET[CMD_LSB +: CMD_W];
         key       <= COMMAND_CONTROL_RESET[KEY_LSB +: KEY_W];
         cfg       <= CONFIG_RESET;
         irq_en    <= IRQ_ENABLE_RESET;
         irq_err   <= 1'b0;
         prog_err  <= 1'b0;
         lock_err  <= 1'b0;
         array_err <= 1'b0;
         location  <= LOCATION_RESET;
         op_held   <= OP_NONE;
         op_loc    <= LOCATION_RESET;
         rdata     <= 32'h0000_0000;
         rerr      <= 1'b0;
      end else if (ce) begin
         state     <= next_state;
         cmd       <= next_cmd;
         key       <= next_key;
         cfg       <= next_cfg;
         irq_en    <= next_irq_en;
         irq_err   <= next_irq_err;
         prog_err  <= next_prog_err;
         lock_err  <= next_lock_err;
         array_err <= next_array_err;
         location  <= next_location;
         op_held   <= next_op_held;
         op_loc    <= next_op_loc;
         rdata     <= next_rdata;
         rerr      <= next_rerr;
      end
   end

endmodule : nvm_command_register_interface

//--- test/nvm_array_model.sv
// Purpose: Behavioural memory array that answers start pulses
// Assumes: One clock; lat sets the cycles from start to done
// Notes:   Faults are not modelled
`timescale 1ns/1ps
module nvm_array_model
   import nvm_cmd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Command side
   input  array_cmd_t      cmd,
   input  wire logic [3:0] lat,
   output logic            idle,
   output logic            done
);
   logic [3:0] cnt;
   // ==========================================
   // Busy timer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idle <= 1'b1;
         done <= 1'b0;
         cnt  <= 4'h0;
      end else begin
         done <= 1'b0;
         if (cmd.start) begin
            idle <= 1'b0;
            cnt  <= lat;
         end else if (!idle && cnt == 4'h0) begin
            done <= 1'b1;
            idle <= 1'b1;
         end else if (!idle) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : nvm_array_model

//--- test/nvm_command_register_interface_monitor.sv
// Purpose: Port-level assertions for the command register interface
// Assumes: ce held high; master keeps away from the key while a command is pending
// Notes:   Pending tracking covers main erase and page write only
`timescale 1ns/1ps
module nvm_command_register_interface_monitor
   import nvm_cmd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  reg_req_t         req,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   input  wire logic        mem_access,
   input  wire logic        mem_busy,
   input  wire logic        mem_stall,
   input  array_cmd_t       array_cmd,
   input  wire logic        array_idle,
   input  wire logic        array_done,
   input  wire logic        module_enabled,
   input  wire logic [31:0] config_out
);
   logic acc, key_wr, key_ok, quiet, mapped, pend_r, next_pend_r;
   assign acc    = req.sel && req.enable;
   assign key_wr = acc && req.write && req.addr == OFS_COMMAND_CONTROL && req.strb[1];
   assign key_ok = key_wr && req.wdata[15:8] == EXECUTION_KEY_VALUE && req.strb[0] && !pend_r && !mem_stall;
   assign quiet  = !mem_access && !mem_busy && array_idle;
   assign mapped = req.addr <= OFS_REGION_LOCK_BITS && req.addr[1:0] == 2'b00;
   // ==========================================
   // Pending tracker; aux erase is left out as it may be refused with a programming error
   always_comb begin
      next_pend_r = pend_r;
      if (array_cmd.start)
         next_pend_r = 1'b0;
      else if (key_ok && req.wdata[6:0] inside {CODE_MAIN_ROW_ERASE, CODE_PAGE_WRITE})
         next_pend_r = 1'b1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pend_r <= 1'b0;
      else
         pend_r <= next_pend_r;
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_issue(logic [6:0] c, array_op_t o);
      key_ok && req.wdata[6:0] == c ##1 quiet |=> array_cmd.start && array_cmd.op == o;
   endproperty
   AST_ISSUE_ERASE: assert property (p_issue(CODE_MAIN_ROW_ERASE, OP_MAIN_ERASE))
      else $error("Main erase did not start");
   AST_ISSUE_PAGE: assert property (p_issue(CODE_PAGE_WRITE, OP_PAGE_WRITE))
      else $error("Page write did not start");
   AST_BAD_KEY: assert property (
      key_wr && req.wdata[15:8] != EXECUTION_KEY_VALUE && !pend_r && !mem_stall |=> !array_cmd.start [*3])
      else $error("Start after a wrong key");
   AST_RESERVED: assert property (
      key_ok && req.wdata[6:0] inside {7'h00, 7'h01, 7'h03} |=> !array_cmd.start [*3])
      else $error("Reserved code started the array");
   AST_DEFER: assert property (pend_r && !quiet |=> !array_cmd.start)
      else $error("Start while memory bus or array busy");
   AST_STALL_START: assert property (array_cmd.start |-> mem_stall)
      else $error("No stall during start");
   AST_STALL_END: assert property ($fell(mem_stall) |-> $past(array_done))
      else $error("Stall ended without done");
   AST_UNMAPPED: assert property (acc |=> pslverr == !$past(mapped))
      else $error("Wrong error response");
   AST_KEY_READ: assert property (
      acc && !req.write && req.addr == OFS_COMMAND_CONTROL && pend_r && !array_cmd.start |=> prdata[KEY_LSB])
      else $error("Key bit zero not set while pending");
   AST_CONFIG_PROT: assert property (
      acc && req.write && req.addr == OFS_CONTROLLER_CONFIG && module_enabled |=> $stable(config_out))
      else $error("Config written while enabled");
   cover property (array_cmd.start);
   cover property (pend_r && !quiet);
   cover property (pslverr);
endmodule : nvm_command_register_interface_monitor
bind nvm_command_register_interface nvm_command_register_interface_monitor mon_u (
   .clk, .rst, .req, .prdata, .pslverr, .mem_access, .mem_busy, .mem_stall,
   .array_cmd, .array_idle, .array_done, .module_enabled, .config_out);

//--- test/nvm_command_register_interface_tb.sv
// Purpose: Self-checking bench for the command register interface
// Assumes: ce and page_loaded held high; read data sampled two edges after the access
// Notes:   Array timing comes from a model with settable latency
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module nvm_command_register_interface_tb
   import nvm_cmd_pkg::*;
;
   logic        clk, rst, ce, pready, pslverr, mem_access, mem_busy, mem_addr_load, mem_stall;
   logic        array_idle, array_done, array_fault, module_enabled, security_set, page_loaded;
   logic [31:0] prdata, config_out;
   logic [21:0] mem_addr;
   logic [3:0]  lat;
   reg_req_t    req;
   array_cmd_t  array_cmd;
   int          bad_count = 0;
   int          n_compared = 0;
   nvm_command_register_interface dut_u (.clk, .rst, .ce, .req, .prdata, .pready, .pslverr,
      .mem_access, .mem_busy, .mem_addr_load, .mem_addr, .mem_stall, .array_cmd, .array_idle,
      .array_done, .array_fault, .module_enabled, .security_set, .page_loaded, .config_out);
   nvm_array_model model_u (.clk, .rst, .cmd(array_cmd), .lat, .idle(array_idle), .done(array_done));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================
   // Bus tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      req <= '{sel: 1'b1, enable: 1'b1, write: 1'b1, addr: a, wdata: d, strb: s};
      @(posedge clk);
      req <= '0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      req <= '{sel: 1'b1, enable: 1'b1, write: 1'b0, addr: a, wdata: 32'h0, strb: 4'h0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      `CHK(prdata & m, e)
   endtask : rdc
   task automatic wait_start(input array_op_t o, input logic [21:0] l);
      for (int i = 0; i < 20 && array_cmd.start !== 1'b1; i++) @(posedge clk);
      `CHK(array_cmd.start, 1'b1)
      `CHK(array_cmd.op, o)
      `CHK(array_cmd.location, l)
   endtask : wait_start
   task automatic wait_idle();
      for (int i = 0; i < 40 && mem_stall !== 1'b0; i++) @(posedge clk);
      `CHK(mem_stall, 1'b0)
   endtask : wait_idle
   task automatic idle_check(input int n);
      repeat (n) begin
         @(posedge clk);
         `CHK(array_cmd.start, 1'b0)
      end
   endtask : idle_check
   task automatic complete_run();
      $display("TB: compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // Far above the fewer than two hundred cycles needed
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   // ==========================================
   // Sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      req = '0;
      mem_access = 1'b0;
      mem_busy = 1'b0;
      mem_addr_load = 1'b0;
      mem_addr = 22'h00_0000;
      array_fault = 1'b0;
      module_enabled = 1'b0;
      security_set = 1'b0;
      page_loaded = 1'b1;
      lat = 4'hF;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdc(OFS_COMMAND_CONTROL, 32'h0000_0000, 32'h0000_FFFF);
      rdc(OFS_CONTROLLER_CONFIG, 32'h0000_0080, 32'hFFFF_FFFF);
      module_enabled <= 1'b1;
      wr(OFS_CONTROLLER_CONFIG, 32'hFFFF_FFFF, 4'hF);
      rdc(OFS_CONTROLLER_CONFIG, 32'h0000_0080, 32'hFFFF_FFFF);
      module_enabled <= 1'b0;
      wr(OFS_CONTROLLER_CONFIG, 32'hFFFF_FFFF, 4'hF);
      rdc(OFS_CONTROLLER_CONFIG, 32'h0007_039E, 32'hFFFF_FFFF);
      `CHK(config_out, 32'h0007_039E)
      wr(OFS_TARGET_LOCATION, 32'h00AB_0000, 4'h4);
      wr(OFS_TARGET_LOCATION, 32'h0000_1234, 4'h3);
      rdc(OFS_TARGET_LOCATION, 32'h002B_1234, 32'hFFFF_FFFF);
      mem_busy <= 1'b1;
      wr(OFS_COMMAND_CONTROL, 32'h0000_A502, 4'h3);
      rdc(OFS_COMMAND_CONTROL, 32'h0000_0100, 32'h0000_0100);
      idle_check(4);
      mem_busy <= 1'b0;
      wait_start(OP_MAIN_ERASE, 22'h2B_1234);
      rdc(OFS_IRQ_FLAGS, 32'h0, 32'h1);
      wr(OFS_COMMAND_CONTROL, 32'h0000_A504, 4'h3);
      wait_idle();
      rdc(OFS_CONTROLLER_STATE, 32'h4, 32'h4);
      rdc(OFS_IRQ_FLAGS, 32'h3, 32'h3);
      wr(OFS_CONTROLLER_STATE, 32'h4, 4'h1);
      wr(OFS_IRQ_FLAGS, 32'h2, 4'h1);
      rdc(OFS_IRQ_FLAGS, 32'h1, 32'h3);
      lat <= 4'h2;
      wr(OFS_COMMAND_CONTROL, 32'h0000_0004, 4'h1);
      idle_check(4);
      wr(OFS_COMMAND_CONTROL, 32'h0000_3C02, 4'h3);
      idle_check(3);
      rdc(OFS_CONTROLLER_STATE, 32'h4, 32'h4);
      wr(OFS_CONTROLLER_STATE, 32'h4, 4'h1);
      wr(OFS_COMMAND_CONTROL, 32'h0000_A503, 4'h3);
      idle_check(3);
      rdc(OFS_CONTROLLER_STATE, 32'h0, 32'h4);
      mem_access <= 1'b1;
      wr(OFS_COMMAND_CONTROL, 32'h0000_A504, 4'h3);
      mem_access <= 1'b0;
      wait_start(OP_PAGE_WRITE, 22'h2B_1234);
      wait_idle();
      security_set <= 1'b1;
      wr(OFS_COMMAND_CONTROL, 32'h0000_A505, 4'h3);
      idle_check(3);
      rdc(OFS_CONTROLLER_STATE, 32'h4, 32'h4);
      wr(OFS_CONTROLLER_STATE, 32'h4, 4'h1);
      security_set <= 1'b0;
      mem_addr_load <= 1'b1;
      mem_addr <= 22'h00_0010;
      @(posedge clk);
      mem_addr_load <= 1'b0;
      rdc(OFS_TARGET_LOCATION, 32'h0000_0010, 32'hFFFF_FFFF);
      wr(OFS_COMMAND_CONTROL, 32'h0000_A505, 4'h3);
      wait_start(OP_AUX_ERASE, 22'h00_0010);
      wait_idle();
      rdc(8'h40, 32'h0, 32'hFFFF_FFFF);
      `CHK({pready, pslverr}, 2'b11)
      complete_run();
   end
endmodule : nvm_command_register_interface_tb
